// ===== hw/prot_pkg.sv
/*
 * Shared constants and types for the battery protection register block:
 * register indices, field positions, reset values, threshold scaling and
 * the regulation timeout.
 * Assumes a 10 MHz register clock; register bytes sit at four times the
 * index on a 32-bit APB bus.
 */
package prot_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_OVP_CFG = 8'h08;
   localparam logic [7:0] IDX_OCP_CFG = 8'h09;
   localparam logic [7:0] IDX_REG_CTL = 8'h0A;
   localparam logic [7:0] IDX_FLAGS = 8'h0B;
   localparam logic [7:0] IDX_MASK = 8'h0C;

   // reset values
   localparam logic [7:0] RST_OVP_CFG = 8'h8E;
   localparam logic [7:0] RST_OCP_CFG = 8'hB4;
   localparam logic [7:0] RST_REG_CTL = 8'h24;
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_MASK = 8'h00;

   // field positions
   localparam int EN_BIT = 7;
   localparam int TMO_DIS_BIT = 6;
   localparam int IREG_EN_BIT = 5;
   localparam int IREG_LSB = 3;
   localparam int VREG_EN_BIT = 2;
   localparam int VREG_LSB = 0;

   // writable bits per register; reserved bits read as zero
   localparam logic [7:0] WMASK_THR = 8'hBF;
   localparam logic [7:0] WMASK_REG = 8'h7F;

   // flags that stay set while their cause persists (bits 7,6,5,3)
   localparam logic [7:0] FLAG_PERSIST = 8'hE8;

   ////////////////////////////////////////////////////////////////////////
   // threshold scaling, millivolts and milliamps
   localparam logic [13:0] OVP_BASE_MV = 14'h0FA0;   // 4 V
   localparam logic [13:0] OVP_STEP_MV = 14'h0019;   // 25 mV
   localparam logic [5:0] OVP_SAT_CODE = 6'h28;
   localparam logic [13:0] OVP_MAX_MV = 14'h1388;    // 5 V
   localparam logic [13:0] OCP_BASE_MA = 14'h07D0;   // 2 A
   localparam logic [13:0] OCP_STEP_MA = 14'h0064;   // 100 mA
   localparam logic [5:0] OCP_SAT_CODE = 6'h34;
   localparam logic [13:0] OCP_MAX_MA = 14'h1C20;    // 7.2 A
   localparam logic [13:0] VREG_BASE_MV = 14'h0032;  // 50 mV
   localparam logic [13:0] VREG_STEP_MV = 14'h0032;  // 50 mV
   localparam logic [13:0] IREG_BASE_MA = 14'h00C8;  // 200 mA
   localparam logic [13:0] IREG_STEP_MA = 14'h0064;  // 100 mA

   ////////////////////////////////////////////////////////////////////////
   // regulation timeout
   localparam longint CLK_HZ = 64'd10_000_000;
   localparam longint REG_TIMEOUT_MS = 64'd650;
   localparam longint REG_TIMEOUT_CYCLES = REG_TIMEOUT_MS * CLK_HZ / 64'd1000;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WAIT = 3'b010,
      BUS_DONE = 3'b100
   } bus_state_e;

   // analog-side status levels
   typedef struct packed {
      logic [7:0] fault;          // flag causes, bit order of the flag reg
      logic volt_regulating;      // battery voltage loop is regulating
      logic curr_regulating;      // battery current loop is regulating
   } sense_s;

   // decoded settings toward the analog side
   typedef struct packed {
      logic ovp_enable;
      logic [13:0] ovp_mv;
      logic ocp_enable;
      logic [13:0] ocp_ma;
      logic volt_reg_enable;
      logic [13:0] volt_reg_mv;
      logic curr_reg_enable;
      logic [13:0] curr_reg_ma;
      logic ovp_deglitch_long;
      logic ocp_deglitch_long;
      logic charge_stop;
   } limits_s;

endpackage

// ===== hw/threshold_decode.sv
/*
 * Turns a 6-bit threshold code into a linear value with an upper clamp.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module threshold_decode #(
   parameter logic [13:0] BASE = 14'h0000,
   parameter logic [13:0] STEP = 14'h0001,
   parameter logic [5:0] SAT_CODE = 6'h3F,
   parameter logic [13:0] MAX = 14'h3FFF
) (
   // setting
   input wire logic [5:0] code,
   // scaled threshold
   output logic [13:0] value
);

   logic [13:0] product;

   // codes at or above saturation pin to the maximum
   always_comb begin
      product = 14'(STEP * {8'h00, code});
      if (code >= SAT_CODE) begin
         value = MAX;
      end else begin
         value = 14'(BASE + product);
      end
   end

endmodule

`default_nettype wire

// ===== hw/battery_protect_fault_regs.sv
/*
 * Battery protection settings and first fault flag register, APB slave.
 * Holds over-voltage / over-current thresholds, regulation enables and
 * margins, the regulation timeout, read-to-clear fault flags and the
 * interrupt mask, and drives an active-low interrupt.
 * Assumes sense inputs are synchronous to pclk and APB follows the usual
 * setup/access protocol.
 */
//
// Contract
// R01 - ovp config bit 7 enables battery over-voltage protection, reset on
// R02 - ovp threshold is 4 V plus code times 25 mV, default 4.35 V
// R03 - ovp codes at or above saturation give 5 V
// R04 - ocp config bit 7 enables battery over-current protection, reset on
// R05 - ocp threshold is 2 A plus code times 100 mA
// R06 - ocp codes at or above saturation clamp to 7.2 A, the default
// R07 - regulation longer than 650 ms stops charging unless timeout disabled
// R08 - current regulation enable default on; stretches ocp deglitch to 500 us
// R09 - current regulation starts 200..500 mA below ocp threshold
// R10 - voltage regulation enable default on; stretches ovp deglitch to 500 us
// R11 - voltage regulation starts 50..200 mV below ovp threshold
// R12 - flag bits 7..0 in fixed order, each raises interrupt unless masked
// R13 - persistent flags clear on read only after their cause has gone
// R14 - event flags clear on every read regardless of condition
// R15 - masked flags still set but do not raise the interrupt
// R16 - interrupt stays low while any unmasked flag is set
`timescale 1ns/1ps
`default_nettype none

module battery_protect_fault_regs #(
   parameter int unsigned TIMEOUT_CYCLES =
      int'(prot_pkg::REG_TIMEOUT_CYCLES)
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // analog side
   input wire prot_pkg::sense_s sense,
   output prot_pkg::limits_s limits,
   // interrupt
   output logic interrupt_out_n
);

   localparam int CW = $clog2(TIMEOUT_CYCLES + 1);

   ////////////////////////////////////////////////////////////////////////
   // address decode, shared by reads and writes

   function automatic logic [7:0] reg_index(input logic [7:0] addr);
      reg_index = {2'b00, addr[7:2]};
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      logic [7:0] idx;
      idx = reg_index(addr);
      is_mapped = (addr[1:0] == 2'b00) &&
                  (idx >= prot_pkg::IDX_OVP_CFG) &&
                  (idx <= prot_pkg::IDX_MASK);
   endfunction

   prot_pkg::bus_state_e state;
   logic [7:0] battery_overvoltage_config;
   logic [7:0] battery_overcurrent_config;
   logic [7:0] regulation_control;
   logic [7:0] fault_flags_first;
   logic [7:0] interrupt_mask_first;
   logic [7:0] fault_prev;
   logic [7:0] read_clear;
   logic [7:0] write_clear;
   logic [7:0] rdata_mux;
   logic [CW-1:0] reg_timer;
   logic wr_done;
   logic rd_done;
   logic [7:0] acc_idx;
   logic lane0;
   logic [13:0] ovp_mv;
   logic [13:0] ocp_mv;
   logic [13:0] next_vreg_mv;
   logic [13:0] next_ireg_ma;
   logic regulating;

   assign acc_idx = reg_index(paddr);
   assign lane0 = pstrb[0];
   // a transfer completes on the edge where the slave shows pready
   assign wr_done = psel && penable && pready && pwrite && is_mapped(paddr);
   assign rd_done = psel && penable && pready && !pwrite && is_mapped(paddr);

   ////////////////////////////////////////////////////////////////////////
   // bus handshake: two wait states so read data comes from a register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= prot_pkg::BUS_IDLE;
      end else begin
         case (state)
            prot_pkg::BUS_IDLE: begin
               if (psel && penable) begin
                  state <= prot_pkg::BUS_WAIT;
               end
            end
            prot_pkg::BUS_WAIT: begin
               state <= prot_pkg::BUS_DONE;
            end
            prot_pkg::BUS_DONE: begin
               state <= prot_pkg::BUS_IDLE;
            end
            default: begin
               state <= prot_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // pready rises for one cycle, with prdata on reads and pslverr on unmapped addresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= (state == prot_pkg::BUS_WAIT);
         pslverr <= (state == prot_pkg::BUS_WAIT) && !is_mapped(paddr);
         if (state == prot_pkg::BUS_WAIT && !pwrite) begin
            prdata <= {24'h000000, rdata_mux};
         end else if (state == prot_pkg::BUS_DONE) begin
            prdata <= 32'h00000000;
         end
      end
   end

   // read mux; reserved bits are held zero in storage
   always_comb begin
      rdata_mux = 8'h00;
      if (is_mapped(paddr)) begin
         case (acc_idx)
            prot_pkg::IDX_OVP_CFG: rdata_mux = battery_overvoltage_config;
            prot_pkg::IDX_OCP_CFG: rdata_mux = battery_overcurrent_config;
            prot_pkg::IDX_REG_CTL: rdata_mux = regulation_control;
            prot_pkg::IDX_FLAGS: rdata_mux = fault_flags_first;
            prot_pkg::IDX_MASK: rdata_mux = interrupt_mask_first;
            default: rdata_mux = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers, byte lane 0 only

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         battery_overvoltage_config <= prot_pkg::RST_OVP_CFG;   // see R01
         battery_overcurrent_config <= prot_pkg::RST_OCP_CFG;   // see R04
         regulation_control <= prot_pkg::RST_REG_CTL;   // see R08
         interrupt_mask_first <= prot_pkg::RST_MASK;
      end else if (wr_done && lane0) begin
         case (acc_idx)
            prot_pkg::IDX_OVP_CFG: begin
               battery_overvoltage_config <=
                  pwdata[7:0] & prot_pkg::WMASK_THR;
            end
            prot_pkg::IDX_OCP_CFG: begin
               battery_overcurrent_config <=
                  pwdata[7:0] & prot_pkg::WMASK_THR;
            end
            prot_pkg::IDX_REG_CTL: begin
               regulation_control <= pwdata[7:0] & prot_pkg::WMASK_REG;
            end
            prot_pkg::IDX_MASK: begin
               interrupt_mask_first <= pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault flags
   // only bits that were returned as one are cleared by the read, so a
   // flag that rises between the data capture and the completion survives

   always_comb begin
      read_clear = 8'h00;
      write_clear = 8'h00;
      if (rd_done && acc_idx == prot_pkg::IDX_FLAGS) begin
         read_clear = prdata[7:0];
      end
      if (wr_done && lane0 && acc_idx == prot_pkg::IDX_FLAGS) begin
         write_clear = pwdata[7:0];   // one to clear, same gating as reads
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_prev <= 8'h00;
      end else begin
         fault_prev <= sense.fault;
      end
   end

   // flags are set regardless of the mask; set always beats clear
   generate
      for (genvar b = 0; b < 8; b++) begin : g_flag
         logic set_evt;
         logic clr_req;
         if (prot_pkg::FLAG_PERSIST[b]) begin : g_persist
            // level set: a clear cannot win while the cause persists
            assign set_evt = sense.fault[b];   // see R13
         end else begin : g_event
            // edge set: a read clears whatever the present level
            assign set_evt = sense.fault[b] && !fault_prev[b];   // see R14
         end
         assign clr_req = read_clear[b] || write_clear[b];
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               fault_flags_first[b] <= prot_pkg::RST_FLAGS[b];
            end else if (set_evt) begin
               fault_flags_first[b] <= 1'b1;   // see R12, R15
            end else if (clr_req) begin
               fault_flags_first[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // low while any unmasked flag stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_out_n <= 1'b1;
      end else begin
         interrupt_out_n <=
            ~|(fault_flags_first & ~interrupt_mask_first);   // see R15, R16
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // threshold decode

   threshold_decode #(
      .BASE(prot_pkg::OVP_BASE_MV),
      .STEP(prot_pkg::OVP_STEP_MV),
      .SAT_CODE(prot_pkg::OVP_SAT_CODE),
      .MAX(prot_pkg::OVP_MAX_MV)
   ) u_ovp_decode (
      .code(battery_overvoltage_config[5:0]),   // see R02, R03
      .value(ovp_mv)
   );

   threshold_decode #(
      .BASE(prot_pkg::OCP_BASE_MA),
      .STEP(prot_pkg::OCP_STEP_MA),
      .SAT_CODE(prot_pkg::OCP_SAT_CODE),
      .MAX(prot_pkg::OCP_MAX_MA)
   ) u_ocp_decode (
      .code(battery_overcurrent_config[5:0]),   // see R05, R06
      .value(ocp_mv)
   );

   // regulation points sit a margin below the protection thresholds
   // the largest margin is far below the lowest threshold, so the
   // subtraction never wraps
   always_comb begin
      next_vreg_mv = 14'(ovp_mv - prot_pkg::VREG_BASE_MV -
         14'(prot_pkg::VREG_STEP_MV *
         {12'h000, regulation_control[prot_pkg::VREG_LSB +: 2]}));   // see R11
      next_ireg_ma = 14'(ocp_mv - prot_pkg::IREG_BASE_MA -
         14'(prot_pkg::IREG_STEP_MA *
         {12'h000, regulation_control[prot_pkg::IREG_LSB +: 2]}));   // see R09
   end

   ////////////////////////////////////////////////////////////////////////
   // regulation timeout
   // a disabled loop is not counted as regulating

   assign regulating =
      (sense.volt_regulating && regulation_control[prot_pkg::VREG_EN_BIT]) ||
      (sense.curr_regulating && regulation_control[prot_pkg::IREG_EN_BIT]);

   // saturating count of regulating cycles; it runs even with the timeout
   // disabled, the stop itself is gated by the disable bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_timer <= '0;
      end else if (!regulating) begin
         reg_timer <= '0;
      end else if (reg_timer != CW'(TIMEOUT_CYCLES)) begin
         reg_timer <= reg_timer + CW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs toward the analog side
   // charge_stop latches; only reset or setting the disable bit ends it,
   // so charging never resumes behind software's back

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limits <= '0;
      end else begin
         limits.ovp_enable <=
            battery_overvoltage_config[prot_pkg::EN_BIT];   // see R01
         limits.ovp_mv <= ovp_mv;
         limits.ocp_enable <=
            battery_overcurrent_config[prot_pkg::EN_BIT];   // see R04
         limits.ocp_ma <= ocp_mv;

         // regulation loops, enables and points
         limits.volt_reg_enable <=
            regulation_control[prot_pkg::VREG_EN_BIT];   // see R10
         limits.volt_reg_mv <= next_vreg_mv;   // see R11
         limits.curr_reg_enable <=
            regulation_control[prot_pkg::IREG_EN_BIT];   // see R08
         limits.curr_reg_ma <= next_ireg_ma;   // see R09

         // a disabled loop never regulates, so it keeps the short
         // deglitch even if the analog side reports regulation
         limits.ovp_deglitch_long <= sense.volt_regulating &&
            regulation_control[prot_pkg::VREG_EN_BIT];   // see R10
         limits.ocp_deglitch_long <= sense.curr_regulating &&
            regulation_control[prot_pkg::IREG_EN_BIT];   // see R08

         // setting the disable bit is also how software lets charging
         // resume after a timeout
         if (regulation_control[prot_pkg::TMO_DIS_BIT]) begin
            limits.charge_stop <= 1'b0;   // see R07
         end else if (regulating && reg_timer == CW'(TIMEOUT_CYCLES)) begin
            limits.charge_stop <= 1'b1;   // see R07
         end
      end
   end

endmodule

`default_nettype wire

// ===== dv/analog_sense_model.sv
/*
 Stand-in for the analog side: turns bench commands into sense levels.
 Assumes commands change just after a rising pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module analog_sense_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // commands from the bench
   input wire logic [7:0] fault_cmd,
   input wire logic vreg_cmd,
   input wire logic ireg_cmd,
   // toward the block
   output prot_pkg::sense_s sense
);
   // comparators settle within a clock, so one stage models them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense <= '0;
      end else begin
         sense <= {fault_cmd, vreg_cmd, ireg_cmd};
      end
   end
endmodule

`default_nettype wire

// ===== dv/battery_protect_fault_regs_monitor.sv
/*
 Port checker for the protection register block, bound to it.
 Assumes pclk and presetn of the block are the only clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module battery_protect_fault_regs_checker (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // analog side
   input wire prot_pkg::sense_s sense,
   input wire prot_pkg::limits_s limits
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // a loop that has been regulating for three cycles
   sequence s_vreg;
      (limits.volt_reg_enable && sense.volt_regulating) [*3];
   endsequence
   sequence s_ireg;
      (limits.curr_reg_enable && sense.curr_regulating) [*3];
   endsequence

   ////////////////////////////////////////////////////////////////////
   a_ovp_clamp: assert property (
      limits.ovp_mv <= prot_pkg::OVP_MAX_MV)
      else $error("ovp threshold above ceiling");
   // limits load one edge after reset lets go, hence the past guard
   a_ovp_grid: assert property (
      $past(presetn) |-> limits.ovp_mv >= prot_pkg::OVP_BASE_MV &&
      (limits.ovp_mv - prot_pkg::OVP_BASE_MV) % 14'h0019 == 14'h0000)
      else $error("ovp threshold off grid");
   a_ocp_clamp: assert property (
      limits.ocp_ma <= prot_pkg::OCP_MAX_MA)
      else $error("ocp threshold above ceiling");
   a_ocp_grid: assert property (
      $past(presetn) |-> limits.ocp_ma >= prot_pkg::OCP_BASE_MA &&
      (limits.ocp_ma - prot_pkg::OCP_BASE_MA) % 14'h0064 == 14'h0000)
      else $error("ocp threshold off grid");
   a_vreg_margin: assert property (
      $past(presetn) |-> (limits.ovp_mv - limits.volt_reg_mv) inside
      {14'h0032, 14'h0064, 14'h0096, 14'h00C8})
      else $error("voltage margin illegal");
   a_ireg_margin: assert property (
      $past(presetn) |-> (limits.ocp_ma - limits.curr_reg_ma) inside
      {14'h00C8, 14'h012C, 14'h0190, 14'h01F4})
      else $error("current margin illegal");
   a_ovp_stretch: assert property (
      s_vreg |-> ##[0:3] limits.ovp_deglitch_long)
      else $error("ovp deglitch not stretched");
   a_ocp_stretch: assert property (
      s_ireg |-> ##[0:3] limits.ocp_deglitch_long)
      else $error("ocp deglitch not stretched");
   a_stop_cause: assert property (
      $rose(limits.charge_stop) |->
      $past(sense.volt_regulating || sense.curr_regulating))
      else $error("charge stopped without regulation");
   a_apb_answer: assert property (
      psel && penable |-> ##[0:8] pready)
      else $error("apb access not answered");
endmodule

bind battery_protect_fault_regs battery_protect_fault_regs_checker
   battery_protect_fault_regs_checker_i (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pready(pready),
   .sense(sense),
   .limits(limits)
);

`default_nettype wire

// ===== dv/battery_protect_fault_regs_bench.sv
/*
 Self-checking bench for the protection register block over APB.
 Assumes a 10 MHz pclk; timeout shortened through TIMEOUT_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none

module battery_protect_fault_regs_bench;
   localparam int unsigned TMO = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic slv_err;
   logic [7:0] fault_cmd = 8'h00;
   logic vreg_cmd = 1'b0;
   logic ireg_cmd = 1'b0;
   logic interrupt_out_n;
   prot_pkg::sense_s sense;
   prot_pkg::limits_s limits;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [5:0] codes [8] = '{6'h00, 6'h01, 6'h0E, 6'h27, 6'h28,
      6'h33, 6'h34, 6'h3F};

   always #50 pclk = ~pclk;

   battery_protect_fault_regs #(.TIMEOUT_CYCLES(TMO))
   battery_protect_fault_regs_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .sense(sense), .limits(limits),
      .interrupt_out_n(interrupt_out_n));

   analog_sense_model analog_sense_model_i (.pclk(pclk),
      .presetn(presetn), .fault_cmd(fault_cmd), .vreg_cmd(vreg_cmd),
      .ireg_cmd(ireg_cmd), .sense(sense));

   ////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // a hang is cut short here rather than by the simulator
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         tally_and_finish;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx[5:0], 2'b00};
      pwdata <= d;
      pstrb <= w ? 4'hF : 4'h0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      slv_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, idx, d, q);
      tick(2);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, idx, 32'h0, q);
      chk(q, e);
   endtask

   function automatic logic [13:0] ovp_exp(input logic [5:0] c);
      return (c >= 6'h28) ? 14'h1388 : 14'h0FA0 + 14'(c) * 14'h0019;
   endfunction

   function automatic logic [13:0] ocp_exp(input logic [5:0] c);
      return (c >= 6'h34) ? 14'h1C20 : 14'h07D0 + 14'(c) * 14'h0064;
   endfunction

   // a short fault pulse, then time for the flag to land
   task automatic pulse(input logic [7:0] f);
      fault_cmd <= f;
      tick(3);
      fault_cmd <= 8'h00;
      tick(4);
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdc(prot_pkg::IDX_OVP_CFG, 32'h8E);
      rdc(prot_pkg::IDX_OCP_CFG, 32'hB4);
      rdc(prot_pkg::IDX_REG_CTL, 32'h24);
      rdc(prot_pkg::IDX_FLAGS, 32'h00);
      rdc(prot_pkg::IDX_MASK, 32'h00);
      chk(32'(limits.ovp_mv), 32'h10FE);
      chk(32'(limits.ocp_ma), 32'h1C20);
      chk(32'(limits.volt_reg_mv), 32'h10CC);
      chk(32'(limits.curr_reg_ma), 32'h1B58);
      chk(32'({limits.ovp_enable, limits.ocp_enable}), 32'h3);
      chk(32'(interrupt_out_n), 32'h1);
      wr(8'h1F, 32'hFF);
      chk(32'(slv_err), 32'h1);
      rdc(prot_pkg::IDX_OVP_CFG, 32'h8E);
      chk(32'(slv_err), 32'h0);
      $display("test reset done");
   endtask

   // reserved bit 6 written high must read back low
   task automatic t_thresholds;
      foreach (codes[k]) begin
         wr(prot_pkg::IDX_OVP_CFG, {24'h0, 2'b01, codes[k]});
         wr(prot_pkg::IDX_OCP_CFG, {24'h0, 2'b11, codes[k]});
         rdc(prot_pkg::IDX_OVP_CFG, {26'h0, codes[k]});
         rdc(prot_pkg::IDX_OCP_CFG, {24'h0, 2'b10, codes[k]});
         chk(32'(limits.ovp_mv), 32'(ovp_exp(codes[k])));
         chk(32'(limits.ocp_ma), 32'(ocp_exp(codes[k])));
         chk(32'(limits.ovp_enable), 32'h0);
         chk(32'(limits.ocp_enable), 32'h1);
      end
      wr(prot_pkg::IDX_OVP_CFG, 32'h8E);
      wr(prot_pkg::IDX_OCP_CFG, 32'h34);
      chk(32'({limits.ovp_enable, limits.ocp_enable}), 32'h2);
      wr(prot_pkg::IDX_OCP_CFG, 32'hB4);
      $display("test thresholds done");
   endtask

   task automatic t_regulation;
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         wr(prot_pkg::IDX_REG_CTL, {24'h0, 3'b101, m, 1'b1, m});
         rdc(prot_pkg::IDX_REG_CTL, {24'h0, 3'b001, m, 1'b1, m});
         chk(32'(limits.volt_reg_mv), 32'(4300 - 50 * i));
         chk(32'(limits.curr_reg_ma), 32'(7000 - 100 * i));
      end
      wr(prot_pkg::IDX_REG_CTL, 32'h00);
      chk(32'(limits.volt_reg_enable), 32'h0);
      chk(32'(limits.curr_reg_enable), 32'h0);
      $display("test regulation done");
   endtask

   task automatic t_flags;
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         chk(32'(interrupt_out_n), 32'h0);
         rdc(prot_pkg::IDX_FLAGS, 32'h01 << i);
         tick(2);
         chk(32'(interrupt_out_n), 32'h1);
         rdc(prot_pkg::IDX_FLAGS, 32'h00);
      end
      fault_cmd <= 8'hFF;
      tick(3);
      fault_cmd <= 8'hE8;
      tick(4);
      rdc(prot_pkg::IDX_FLAGS, 32'hFF);
      rdc(prot_pkg::IDX_FLAGS, 32'hE8);
      fault_cmd <= 8'h00;
      tick(4);
      rdc(prot_pkg::IDX_FLAGS, 32'hE8);
      rdc(prot_pkg::IDX_FLAGS, 32'h00);
      $display("test flags done");
   endtask

   task automatic t_mask;
      wr(prot_pkg::IDX_MASK, 32'hFF);
      rdc(prot_pkg::IDX_MASK, 32'hFF);
      pulse(8'h84);
      chk(32'(interrupt_out_n), 32'h1);
      rdc(prot_pkg::IDX_FLAGS, 32'h84);
      wr(prot_pkg::IDX_MASK, 32'hFB);
      pulse(8'h84);
      chk(32'(interrupt_out_n), 32'h0);
      rdc(prot_pkg::IDX_FLAGS, 32'h84);
      tick(2);
      chk(32'(interrupt_out_n), 32'h1);
      wr(prot_pkg::IDX_MASK, 32'h00);
      $display("test mask done");
   endtask

   // last: a timed-out charge stop may stay latched
   task automatic t_timeout;
      wr(prot_pkg::IDX_REG_CTL, 32'h64);
      vreg_cmd <= 1'b1;
      tick(TMO + 10);
      chk(32'(limits.ovp_deglitch_long), 32'h1);
      chk(32'(limits.charge_stop), 32'h0);
      vreg_cmd <= 1'b0;
      ireg_cmd <= 1'b1;
      tick(6);
      chk(32'(limits.ocp_deglitch_long), 32'h1);
      wr(prot_pkg::IDX_REG_CTL, 32'h24);
      tick(TMO + 10);
      chk(32'(limits.charge_stop), 32'h1);
      ireg_cmd <= 1'b0;
      $display("test timeout done");
   endtask

   initial begin
      tick(3);
      presetn <= 1'b1;
      tick(2);
      t_reset;
      t_thresholds;
      t_regulation;
      t_flags;
      t_mask;
      t_timeout;
      tally_and_finish;
   end
endmodule

`default_nettype wire
